// *** core/bcc_defs.svh ***
// Constants for the battery capacity counter core
// Function
// - Charge raises capacity; discharge lowers and tallies
// - Capacity capped at learned full, floored zero
// - Valid charge after first empty clears capacity
// - Any reset loads learned full from design
// - Self-discharge tallies only while capacity nonzero
// - Tally clears at full, saturates at maximum
// - Qualified discharge tally becomes learned full
// - Keep flag showing discharge still qualifies
// - Learned full drops at most 256 mAh
// - Activity above dead band; valid after 10 mAh
// - Charge counts scaled by efficiency; LED on
// - Charge compensated temperature and charge level
// - Self-discharge rate doubles per ten degrees
// - Each step removes 1/256 of capacity
// - Empty voltage flags latch until valid charge
// - Empty checks suspended above heavy discharge current
// - Flag charging overvoltage above five percent
// - Reset on power-up and on soft command
// - Learned full scales relative, design scales absolute
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH

// Register word addresses
`define A_CTRL 8'h00
`define A_DCAP 8'h01
`define A_FIRST_EMPTY_VOLTAGE_THRESHOLD 8'h02
`define A_EDVF 8'h03
`define A_CHGV 8'h04
`define A_DBAND 8'h05
`define A_HICUR 8'h06
`define A_SDRATE 8'h07
`define A_EFF 8'h08
`define A_STAT 8'h09
`define A_RM 8'h0A
`define A_DCR 8'h0B
`define A_FCC 8'h0C
`define A_SOC 8'h0D

// Fields
`define CTRL_LED 0
`define CTRL_SRST 1
`define STAT_FAULT 2

// Reset values
`define DCAP_RST 16'h0800
`define FIRST_EMPTY_VOLTAGE_THRESHOLD_RST 16'h0C80
`define EDVF_RST 16'h0BB8
`define CHGV_RST 16'h1068
`define DBAND_RST 16'h0010
`define HICUR_RST 16'h4000
`define SDRATE_RST 8'h00
`define EFF_RST 16'hC0F0

// Counting figures
`define MAH_UNIT 17'h01000
`define VALID_MAH 4'hA
`define LEARN_DROP 16'h0100
`define SD_LIMIT 16'h0100
`define TAL_MAX 16'hFFFF
`define PCT_FULL 23'h000064
`define QET_MID 8'h05
`define QET_HI 8'h0D
`define SD_WT_ROOM 8'h04

// Self-discharge base tick, seconds and clock rate
`define SD_TICK_S 64'h0000000000000280
`define CLK_HZ 64'h0000000007735940

`endif

// *** core/bcc_pkg.sv ***
// Types shared by the battery capacity counter
package bcc_pkg;

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_ACTIVE,
    CS_VALID
  } bcc_chg_e;

  typedef struct packed {
    logic chg_active;
    logic chg_valid;
    logic fault;
    logic discharge_qualified_flag;
    logic edvf;
    logic first_empty_voltage_threshold;
  } bcc_status_s;

endpackage

// *** core/bcc_core.sv ***
// Battery capacity counter: charge accounting, learning, self-discharge
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defs.svh"

module bcc_core #(
  parameter logic [39:0] SD_TICK_CYC = 40'(`SD_TICK_S * `CLK_HZ)
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Measurement front end, same clock
  input wire logic sample_in,
  input wire logic signed [15:0] sense_v_in,
  input wire logic [15:0] pack_v_in,
  input wire logic signed [7:0] temp_c_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Status
  output logic led_on_out,
  output logic [7:0] rel_soc_out,
  output logic [7:0] abs_soc_out,
  output bcc_pkg::bcc_status_s status_out
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic led_en_r;
  logic [15:0] dcap_r;
  logic [15:0] first_empty_voltage_threshold_v_r;
  logic [15:0] edvf_v_r;
  logic [15:0] chgv_r;
  logic [15:0] dband_r;
  logic [15:0] hicur_r;
  logic [7:0] sdrate_r;
  logic [15:0] eff_r;
  logic [15:0] rm_r;
  logic [15:0] dcr_r;
  logic [15:0] fcc_r;
  logic [15:0] sdt_r;
  logic [16:0] acc_r;
  logic [3:0] act_r;
  logic [39:0] pre_r;
  logic [7:0] ivl_r;
  logic first_empty_voltage_threshold_f_r;
  logic edvf_f_r;
  logic vdq_r;
  logic fault_r;
  logic hi_r;
  logic [7:0] rel_r;
  logic [7:0] abs_r;
  logic [15:0] rdata_r;
  bcc_pkg::bcc_chg_e cs_r;
  bcc_pkg::bcc_chg_e cs_nxt;

  ////////////////////////////////////////////////////////////////////
  // Register decode

  wire wr_ctrl = wr_in && (addr_in == `A_CTRL);
  wire wr_stat = wr_in && (addr_in == `A_STAT);
  wire srst = wr_ctrl && wdata_in[`CTRL_SRST];

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      led_en_r <= 1'b0;
      dcap_r <= `DCAP_RST;
      first_empty_voltage_threshold_v_r <= `FIRST_EMPTY_VOLTAGE_THRESHOLD_RST;
      edvf_v_r <= `EDVF_RST;
      chgv_r <= `CHGV_RST;
      dband_r <= `DBAND_RST;
      hicur_r <= `HICUR_RST;
      sdrate_r <= `SDRATE_RST;
      eff_r <= `EFF_RST;
    end else if (wr_in) begin
      case (addr_in)
        `A_CTRL: led_en_r <= wdata_in[`CTRL_LED];
        `A_DCAP: dcap_r <= wdata_in;
        `A_FIRST_EMPTY_VOLTAGE_THRESHOLD: first_empty_voltage_threshold_v_r <= wdata_in;
        `A_EDVF: edvf_v_r <= wdata_in;
        `A_CHGV: chgv_r <= wdata_in;
        `A_DBAND: dband_r <= wdata_in;
        `A_HICUR: hicur_r <= wdata_in;
        `A_SDRATE: sdrate_r <= wdata_in[7:0];
        `A_EFF: eff_r <= wdata_in;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sense classification

  wire signed [16:0] sv17 = {sense_v_in[15], sense_v_in};
  wire signed [16:0] db17 = $signed({1'b0, dband_r});
  wire chg = sv17 > db17;
  wire dsg = sv17 < -db17;
  wire [15:0] abs_v = sense_v_in[15] ? 16'(-sense_v_in) : sense_v_in;

  // Efficiency: trickle figure near full, less for heat
  wire [15:0] near_full = fcc_r - {4'h0, fcc_r[15:4]};
  wire [7:0] eff_sel = (rm_r >= near_full) ? eff_r[15:8] : eff_r[7:0];
  wire [7:0] qet = (temp_c_in >= 8'sd40) ? `QET_HI :
                   (temp_c_in >= 8'sd30) ? `QET_MID : 8'h00;
  wire [7:0] eff_adj = (eff_sel > qet) ? eff_sel - qet : 8'h00;
  wire [23:0] chg_prod = abs_v * eff_adj;
  wire [15:0] add_v = chg ? chg_prod[23:8] : (dsg ? abs_v : 16'h0000);

  // One count per sample at most; a sample worth two units carries over
  wire [16:0] acc_sum = acc_r + {1'b0, add_v};
  wire unit_hit = acc_sum >= `MAH_UNIT;
  wire chg_cnt = sample_in && chg && unit_hit;
  wire dsg_cnt = sample_in && dsg && unit_hit;
  wire [16:0] acc_nxt = !sample_in ? acc_r :
                        !(chg || dsg) ? 17'h00000 :
                        unit_hit ? acc_sum - `MAH_UNIT : acc_sum;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) acc_r <= 17'h00000;
    else acc_r <= acc_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Charge qualification

  wire act_done = (act_r == `VALID_MAH) && chg_cnt;
  wire valid_evt = (cs_r == bcc_pkg::CS_ACTIVE) && act_done;
  wire chg_end = sample_in && !chg;

  always_comb begin
    cs_nxt = cs_r;
    case (cs_r)
      bcc_pkg::CS_IDLE: if (sample_in && chg) cs_nxt = bcc_pkg::CS_ACTIVE;
      bcc_pkg::CS_ACTIVE: begin
        if (chg_end) cs_nxt = bcc_pkg::CS_IDLE;
        else if (act_done) cs_nxt = bcc_pkg::CS_VALID;
      end
      bcc_pkg::CS_VALID: if (chg_end) cs_nxt = bcc_pkg::CS_IDLE;
      default: cs_nxt = bcc_pkg::CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) begin
      cs_r <= bcc_pkg::CS_IDLE;
      act_r <= 4'h0;
    end else begin
      cs_r <= cs_nxt;
      if (cs_nxt == bcc_pkg::CS_IDLE) act_r <= 4'h0;
      else if (chg_cnt && act_r != `VALID_MAH) act_r <= act_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Self-discharge timebase

  // Weight four at room temperature; tick when weighted sum hits four times base
  wire [7:0] wt = (temp_c_in < 8'sd10) ? 8'h01 :
                  (temp_c_in < 8'sd20) ? 8'h02 :
                  (temp_c_in < 8'sd30) ? `SD_WT_ROOM :
                  (temp_c_in < 8'sd40) ? 8'h08 :
                  (temp_c_in < 8'sd50) ? 8'h10 :
                  (temp_c_in < 8'sd60) ? 8'h20 :
                  (temp_c_in < 8'sd70) ? 8'h40 : 8'h80;
  wire [41:0] sd_thr = {SD_TICK_CYC, 2'b00};
  wire [41:0] pre_sum = {2'b00, pre_r} + {34'h0, wt};
  wire sd_tick = pre_sum >= sd_thr;
  wire sd_on = sdrate_r != 8'h00;
  wire sd_step = sd_tick && sd_on && (ivl_r == 8'hFF);

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) begin
      pre_r <= 40'h0000000000;
      ivl_r <= 8'h00;
    end else begin
      pre_r <= sd_tick ? 40'h0000000000 : pre_sum[39:0];
      if (!sd_on) ivl_r <= 8'h00;
      else if (sd_step) ivl_r <= sdrate_r;
      else if (sd_tick) ivl_r <= ivl_r + 8'h01;
    end
  end

  wire [15:0] sd_amt = sd_step ? {8'h00, rm_r[15:8]} : 16'h0000;

  ////////////////////////////////////////////////////////////////////
  // Capacity counters

  wire [18:0] rm_sum = {3'b000, rm_r} + {18'h0, chg_cnt}
                     - {18'h0, dsg_cnt} - {3'b000, sd_amt};
  wire [15:0] rm_clamp = rm_sum[18] ? 16'h0000 :
                         (rm_sum[17:0] > {2'b00, fcc_r}) ? fcc_r :
                         rm_sum[15:0];
  wire full = rm_r == fcc_r;
  wire [15:0] sd_tal = (rm_r != 16'h0000) ? sd_amt : 16'h0000;
  wire [17:0] dcr_sum = {2'b00, dcr_r} + {17'h0, dsg_cnt} + {2'b00, sd_tal};
  wire [15:0] dcr_nxt = full ? 16'h0000 :
                        dcr_sum[17:16] != 2'b00 ? `TAL_MAX : dcr_sum[15:0];
  wire [16:0] sdt_sum = {1'b0, sdt_r} + {1'b0, sd_amt};

  wire drop_big = ({1'b0, dcr_r} + {1'b0, `LEARN_DROP}) < {1'b0, fcc_r};
  wire [15:0] learn_v = drop_big ? fcc_r - `LEARN_DROP : dcr_r;
  wire learn = valid_evt && first_empty_voltage_threshold_f_r && vdq_r;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) rm_r <= 16'h0000;
    else if (srst || (valid_evt && first_empty_voltage_threshold_f_r)) rm_r <= 16'h0000;
    else rm_r <= rm_clamp;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) dcr_r <= 16'h0000;
    else dcr_r <= dcr_nxt;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) fcc_r <= `DCAP_RST;
    else if (srst) fcc_r <= dcap_r;
    else if (learn) fcc_r <= learn_v;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst || full) sdt_r <= 16'h0000;
    else sdt_r <= sdt_sum[16] ? `TAL_MAX : sdt_sum[15:0];
  end

  ////////////////////////////////////////////////////////////////////
  // Voltage flags and qualification

  // The present sample counts too, so the first heavy sample cannot latch a flag
  wire hi_now = sample_in && dsg && (abs_v > hicur_r);
  wire edv_ok = !hi_r && !hi_now;
  wire first_empty_voltage_threshold_set = edv_ok && (pack_v_in < first_empty_voltage_threshold_v_r);
  wire edvf_set = edv_ok && (pack_v_in < edvf_v_r);
  wire [16:0] ov_lim = {1'b0, chgv_r} + {1'b0, chgv_r / 16'h0014};
  wire ov_set = (cs_r != bcc_pkg::CS_IDLE) && ({1'b0, pack_v_in} > ov_lim);
  wire cold_edv = first_empty_voltage_threshold_set && !first_empty_voltage_threshold_f_r && (temp_c_in < 8'sd0);
  wire disq = valid_evt || (sdt_r > `SD_LIMIT) || cold_edv;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) hi_r <= 1'b0;
    else if (sample_in) hi_r <= dsg && (abs_v > hicur_r);
  end

  // Latch wins over the clearing valid charge
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) begin
      first_empty_voltage_threshold_f_r <= 1'b0;
      edvf_f_r <= 1'b0;
    end else begin
      first_empty_voltage_threshold_f_r <= first_empty_voltage_threshold_set || (first_empty_voltage_threshold_f_r && !valid_evt);
      edvf_f_r <= edvf_set || (edvf_f_r && !valid_evt);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) vdq_r <= 1'b0;
    else if (full) vdq_r <= 1'b1;
    else if (disq) vdq_r <= 1'b0;
  end

  // Fault set wins over a software clear in the same cycle
  wire fault_clr = wr_stat && wdata_in[`STAT_FAULT];
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || srst) fault_r <= 1'b0;
    else fault_r <= ov_set || (fault_r && !fault_clr);
  end

  ////////////////////////////////////////////////////////////////////
  // State of charge

  wire [22:0] rm100 = {7'h00, rm_r} * `PCT_FULL;
  wire [22:0] rel_q = rm100 / {7'h00, fcc_r};
  wire [22:0] abs_q = rm100 / {7'h00, dcap_r};

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rel_r <= 8'h00;
      abs_r <= 8'h00;
    end else begin
      rel_r <= (fcc_r == 16'h0000) ? 8'h00 : rel_q[7:0];
      abs_r <= (dcap_r == 16'h0000) ? 8'h00 :
               (abs_q > `PCT_FULL) ? 8'h64 : abs_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port

  bcc_pkg::bcc_status_s st;
  assign st = '{chg_active: cs_r != bcc_pkg::CS_IDLE,
                chg_valid: cs_r == bcc_pkg::CS_VALID,
                fault: fault_r, discharge_qualified_flag: vdq_r, edvf: edvf_f_r, first_empty_voltage_threshold: first_empty_voltage_threshold_f_r};

  wire [15:0] rd_mux =
    (addr_in == `A_CTRL) ? {15'h0000, led_en_r} :
    (addr_in == `A_DCAP) ? dcap_r :
    (addr_in == `A_FIRST_EMPTY_VOLTAGE_THRESHOLD) ? first_empty_voltage_threshold_v_r :
    (addr_in == `A_EDVF) ? edvf_v_r :
    (addr_in == `A_CHGV) ? chgv_r :
    (addr_in == `A_DBAND) ? dband_r :
    (addr_in == `A_HICUR) ? hicur_r :
    (addr_in == `A_SDRATE) ? {8'h00, sdrate_r} :
    (addr_in == `A_EFF) ? eff_r :
    (addr_in == `A_STAT) ? {10'h000, st} :
    (addr_in == `A_RM) ? rm_r :
    (addr_in == `A_DCR) ? dcr_r :
    (addr_in == `A_FCC) ? fcc_r :
    (addr_in == `A_SOC) ? {abs_r, rel_r} : 16'h0000;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) rdata_r <= 16'h0000;
    else rdata_r <= rd_in ? rd_mux : 16'h0000;
  end

  assign rdata_out = rdata_r;
  assign rel_soc_out = rel_r;
  assign abs_soc_out = abs_r;
  assign status_out = st;
  assign led_on_out = led_en_r && (cs_r != bcc_pkg::CS_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  rm_cap_a:
    assert property (rm_r <= fcc_r) else $error("rm above fcc");
  rm_empty_a:
    assert property (valid_evt && first_empty_voltage_threshold_f_r |=> rm_r == 16'h0000)
      else $error("rm not cleared");
  dcr_full_a:
    assert property (full && !srst |=> dcr_r == 16'h0000)
      else $error("tally not cleared at full");
  dcr_sat_a:
    assert property (dcr_r == `TAL_MAX && !full && !srst |=> dcr_r == `TAL_MAX)
      else $error("tally wrapped");
  dcr_empty_a:
    assert property (rm_r == 16'h0000 && !full && !dsg_cnt && !srst |=> $stable(dcr_r))
      else $error("tally moved while empty");
  fcc_srst_a:
    assert property (srst |=> fcc_r == $past(dcap_r))
      else $error("fcc not loaded");
  fcc_drop_a:
    assert property (##1 !$past(srst) |-> {1'b0, fcc_r} + 17'h00100 >= {1'b0, $past(fcc_r)})
      else $error("fcc dropped too far");
  edv_hold_a:
    assert property (first_empty_voltage_threshold_f_r && !valid_evt && !srst |=> first_empty_voltage_threshold_f_r)
      else $error("first_empty_voltage_threshold flag lost");
  edv_hi_a:
    assert property (hi_r && !first_empty_voltage_threshold_f_r && !srst |=> !first_empty_voltage_threshold_f_r)
      else $error("edv checked at high current");
  valid_a:
    assert property (valid_evt && !srst |=> cs_r == bcc_pkg::CS_VALID && act_r == `VALID_MAH)
      else $error("valid charge lost");
  fault_a:
    assert property (ov_set && !srst |=> fault_r) else $error("fault missed");

endmodule // bcc_core

`default_nettype wire

// *** dv/bcc_pack_model.sv ***
// Battery pack model: sense samples, pack voltage and temperature for the core
`timescale 1ns/1ns
`default_nettype none

module bcc_pack_model (
  // Clock
  input wire logic clk_sys_in,
  // Requested pack behaviour
  input wire logic draw_in,
  input wire logic signed [15:0] rate_in,
  input wire logic [15:0] pack_set_in,
  input wire logic signed [7:0] temp_set_in,
  // Front end lines toward the core
  output var logic sample_out = 1'b0,
  output var logic signed [15:0] sense_v_out = 16'sh0000,
  output var logic [15:0] pack_v_out = 16'h1000,
  output var logic signed [7:0] temp_c_out = 8'sh19
);
  ////////////////////////////////////////////////////////////////////////////////
  // Between samples the sense line toggles, so stale data never passes for a sample
  always @(posedge clk_sys_in) begin
    sample_out <= draw_in;
    sense_v_out <= draw_in ? rate_in : ~sense_v_out;
    pack_v_out <= pack_set_in;
    temp_c_out <= temp_set_in;
  end
endmodule // bcc_pack_model

`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the battery capacity counter core
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defs.svh"

module tb_top;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic draw = 1'b0;
  logic signed [15:0] rate = 16'sh0000;
  logic [15:0] pack_set = 16'h1000;
  logic signed [7:0] temp_set = 8'sh19;
  logic sample;
  logic signed [15:0] sense_v;
  logic [15:0] pack_v;
  logic signed [7:0] temp_c;
  logic [15:0] rdata_out;
  logic led_on_out;
  logic [7:0] rel_soc_out;
  logic [7:0] abs_soc_out;
  bcc_pkg::bcc_status_s st;
  logic [15:0] v;
  int err_count = 0;
  int tests_run = 0;
  int t_room;
  int t_hot;

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Short base tick keeps self-discharge steps within 1024 cycles
  bcc_core #(.SD_TICK_CYC(40'h0000000004)) dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .sample_in(sample), .sense_v_in(sense_v), .pack_v_in(pack_v), .temp_c_in(temp_c),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .led_on_out(led_on_out), .rel_soc_out(rel_soc_out),
    .abs_soc_out(abs_soc_out), .status_out(st)
  );

  bcc_pack_model pack (
    .clk_sys_in(clk_sys_in), .draw_in(draw), .rate_in(rate), .pack_set_in(pack_set),
    .temp_set_in(temp_set), .sample_out(sample), .sense_v_out(sense_v),
    .pack_v_out(pack_v), .temp_c_out(temp_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a);
    chk(v, exp);
  endtask

  // n samples at sense s with pack voltage pv, then pack back to nominal
  task automatic run(input int n, input logic signed [15:0] s, input logic [15:0] pv);
    @(posedge clk_sys_in);
    draw <= 1'b1;
    rate <= s;
    pack_set <= pv;
    repeat (n) @(posedge clk_sys_in);
    draw <= 1'b0;
    pack_set <= 16'h1000;
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wait_step(output int t);
    logic [15:0] first;
    rd(`A_RM);
    first = v;
    t = 0;
    while (v === first && t < 4000) begin
      rd(`A_RM);
      t += 2;
    end
    if (t >= 4000) begin
      err_count++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rdchk(`A_DCAP, `DCAP_RST);
    rdchk(`A_FCC, `DCAP_RST);
    rdchk(`A_DBAND, `DBAND_RST);
    rdchk(8'h20, 16'h0000);
    wr(`A_RM, 16'h1234);
    rdchk(`A_RM, 16'h0000);
    chk(16'(st), 16'h0000);
    // Soft reset loads the new design capacity as learned full
    wr(`A_EFF, 16'hFFFF);
    wr(`A_DCAP, 16'h0040);
    wr(`A_CTRL, 16'h0003);
    wr(`A_CTRL, 16'h0001);
    rdchk(`A_FCC, 16'h0040);
    run(80, 16'sh1200, 16'h1000);
    rdchk(`A_RM, 16'h0040);
    rdchk(`A_DCR, 16'h0000);
    chk(16'(st.chg_valid), 16'h0001);
    chk(16'(st.discharge_qualified_flag), 16'h0001);
    chk(16'(led_on_out), 16'h0001);
    chk({abs_soc_out, rel_soc_out}, 16'h6464);
    // Heavy discharge with low pack: empty checks held off
    run(1, 16'sh0001, 16'h1000);
    run(4, 16'shB000, 16'h0C00);
    chk(16'(st.first_empty_voltage_threshold), 16'h0000);
    chk(16'(led_on_out), 16'h0000);
    rdchk(`A_RM, 16'h003C);
    rdchk(`A_DCR, 16'h0003);
    run(76, 16'shF000, 16'h1000);
    rdchk(`A_RM, 16'h0000);
    rdchk(`A_DCR, 16'h004F);
    run(5, 16'sh0001, 16'h0C00);
    chk(16'({st.edvf, st.first_empty_voltage_threshold, st.discharge_qualified_flag}), 16'h0003);
    run(12, 16'sh1200, 16'h1000);
    rdchk(`A_FCC, 16'h004F);
    chk(16'({st.first_empty_voltage_threshold, st.discharge_qualified_flag}), 16'h0000);
    rd(`A_RM);
    chk(16'(v[15:2]), 16'h0000);
    // Learning from a short discharge may only drop by the limit
    wr(`A_DCAP, 16'h0300);
    wr(`A_CTRL, 16'h0003);
    wr(`A_CTRL, 16'h0001);
    run(784, 16'sh1200, 16'h1000);
    rdchk(`A_RM, 16'h0300);
    run(1, 16'sh0001, 16'h1000);
    run(16, 16'shF000, 16'h1000);
    rdchk(`A_DCR, 16'h000F);
    run(5, 16'sh0001, 16'h0C00);
    run(12, 16'sh1200, 16'h1000);
    rdchk(`A_FCC, 16'h0200);
    run(2, 16'sh1200, 16'h1200);
    chk(16'(st.fault), 16'h0001);
    wr(`A_STAT, 16'h0004);
    chk(16'(st.fault), 16'h0000);
    // Self-discharge: proportional step, doubled pace when warmer
    run(1, 16'sh0001, 16'h1000);
    run(528, 16'sh1200, 16'h1000);
    rdchk(`A_RM, 16'h0200);
    wr(`A_SDRATE, 16'h00F0);
    wait_step(t_room);
    rdchk(`A_RM, 16'h01FE);
    rdchk(`A_DCR, 16'h0000);
    wait_step(t_room);
    rdchk(`A_DCR, 16'h0001);
    @(posedge clk_sys_in);
    temp_set <= 8'sh23;
    wait_step(t_hot);
    wait_step(t_hot);
    chk(16'(t_room >= 2 * t_hot - 6 && t_room <= 2 * t_hot + 6), 16'h0001);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
